/* cnsc_pkg.sv */
// Package of shared constants and types for the node switch configuration block
package cnsc_pkg;

    // ==========================================================
    // Selector field layout
    // ==========================================================
    localparam int DIAL_WIDTH        = 4;
    localparam int NODE_WIDTH        = 5;
    localparam int SEL_PROTOCOL_BIT  = 0;
    localparam int SEL_RATE_LO_BIT   = 1;
    localparam int SEL_RATE_HI_BIT   = 2;
    localparam int SEL_WIDTH         = 3;

    // ==========================================================
    // Reset values of the held configuration
    // ==========================================================
    localparam logic [4:0] NODE_RESET      = 5'h00;
    localparam logic       PROTOCOL_RESET  = 1'h0;
    localparam logic [1:0] RATE_RESET      = 2'h3;

    // ==========================================================
    // Bit-rate encodings; code is {rate_hi_off, rate_lo_off}
    // ==========================================================
    localparam int RATE_1000_KHZ = 1000;
    localparam int RATE_800_KHZ  = 800;
    localparam int RATE_500_KHZ  = 500;
    localparam int RATE_250_KHZ  = 250;
    localparam int CLK_KHZ       = 10000;

    // Bit time in system clock cycles, derived from the clock rate
    localparam logic [7:0] BIT_CYC_1000 = 8'(CLK_KHZ / RATE_1000_KHZ);
    localparam logic [7:0] BIT_CYC_800  = 8'(CLK_KHZ / RATE_800_KHZ);
    localparam logic [7:0] BIT_CYC_500  = 8'(CLK_KHZ / RATE_500_KHZ);
    localparam logic [7:0] BIT_CYC_250  = 8'(CLK_KHZ / RATE_250_KHZ);

    typedef enum logic [1:0]
    {
        CNSC_RATE_1000 = 2'h0,
        CNSC_RATE_800  = 2'h1,
        CNSC_RATE_500  = 2'h2,
        CNSC_RATE_250  = 2'h3
    } cnsc_rate_t;

    typedef enum logic
    {
        CNSC_PROTO_PROPRIETARY = 1'h0,
        CNSC_PROTO_OPEN        = 1'h1
    } cnsc_proto_t;

    // Controller position on the bus
    localparam logic [4:0] CONTROLLER_NODE = 5'h00;

endpackage

/* cnsc_if.sv */
// Interface joining the keyboard node to the machine controller side
`timescale 1ns/1ps
interface cnsc_if;
    import cnsc_pkg::*;

    // Configuration shared between the ends
    logic [NODE_WIDTH-1:0] node_id;
    cnsc_rate_t            rate;
    cnsc_proto_t           protocol;
    logic                  config_valid;
    // Controller's own expectations
    cnsc_rate_t            ctrl_rate;
    logic                  ctrl_ready;
    // Keyboard traffic, one byte strobe each way
    logic                  key_valid;
    logic [7:0]            key_data;
    logic                  cmd_valid;
    logic [7:0]            cmd_data;
    // Pointer traffic on the separate port
    logic                  ptr_valid;
    logic [7:0]            ptr_data;

    modport node
    (
        output node_id, rate, protocol, config_valid,
        output key_valid, key_data, ptr_valid, ptr_data,
        input  ctrl_rate, ctrl_ready, cmd_valid, cmd_data
    );

    modport ctrl
    (
        input  node_id, rate, protocol, config_valid,
        input  key_valid, key_data, ptr_valid, ptr_data,
        output ctrl_rate, ctrl_ready, cmd_valid, cmd_data
    );

endinterface

/* cnsc_ctrl.sv */
// Machine controller end: keeps its fixed position and checks node settings
`timescale 1ns/1ps
module cnsc_ctrl
(
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    // Link to the node
    cnsc_if.ctrl                             link,
    // User side
    input  wire logic [1:0]                  rate_cfg,
    input  wire logic                        cmd_req,
    input  wire logic [7:0]                  cmd_byte,
    output logic      [cnsc_pkg::NODE_WIDTH-1:0] seen_node,
    output logic                             node_bad,
    output logic                             rate_mismatch,
    output logic                             key_seen,
    output logic      [7:0]                  key_byte,
    output logic                             ptr_seen,
    output logic      [7:0]                  ptr_byte
);
    import cnsc_pkg::*;

    // ==========================================================
    // Controller configuration
    // ==========================================================
    // Controller rate latched once at reset release
    logic       rate_taken;
    cnsc_rate_t rate_q;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rate_taken <= 1'b0;
            rate_q     <= cnsc_rate_t'(RATE_RESET);
        end
        else if (!rate_taken)
        begin
            rate_taken <= 1'b1;
            rate_q     <= cnsc_rate_t'(rate_cfg);
        end
    end

    assign link.ctrl_rate  = rate_q;
    assign link.ctrl_ready = rate_taken;

    // Command bytes toward the node
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link.cmd_valid <= 1'b0;
            link.cmd_data  <= 8'h00;
        end
        else
        begin
            link.cmd_valid <= cmd_req & rate_taken;
            if (cmd_req)
                link.cmd_data <= cmd_byte;
        end
    end

    // ==========================================================
    // Checks of the node's settings
    // ==========================================================
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            seen_node     <= NODE_RESET;
            node_bad      <= 1'b0;
            rate_mismatch <= 1'b0;
        end
        else if (link.config_valid && rate_taken)
        begin
            seen_node     <= link.node_id;
            // Position zero belongs to the controller alone
            node_bad      <= (link.node_id == CONTROLLER_NODE);
            // Mixed rates on one bus cannot communicate
            rate_mismatch <= (link.protocol == CNSC_PROTO_OPEN)
                             && (link.rate != rate_q);
        end
    end

    // Received keyboard and pointer bytes
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            key_seen <= 1'b0;
            key_byte <= 8'h00;
            ptr_seen <= 1'b0;
            ptr_byte <= 8'h00;
        end
        else
        begin
            key_seen <= link.key_valid;
            ptr_seen <= link.ptr_valid;
            if (link.key_valid)
                key_byte <= link.key_data;
            if (link.ptr_valid)
                ptr_byte <= link.ptr_data;
        end
    end

endmodule

/* cnsc_node.sv */
// Keyboard node end: selector sampling, held configuration and traffic routing
`timescale 1ns/1ps
module cnsc_node
(
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              reset_n,
    // Selector pins, on is high
    input  wire logic [cnsc_pkg::DIAL_WIDTH-1:0]   address_dial,
    input  wire logic                              address_high,
    input  wire logic [cnsc_pkg::SEL_WIDTH-1:0]    mode_switch,
    input  wire logic                              line_termination_select,
    // Link to the controller
    cnsc_if.node                                   link,
    // Key scan side
    input  wire logic                              key_req,
    input  wire logic [7:0]                        key_byte,
    // Pointer side
    input  wire logic                              ptr_req,
    input  wire logic [7:0]                        ptr_byte,
    // Status toward local logic
    output logic      [cnsc_pkg::NODE_WIDTH-1:0]   node_priority,
    output logic      [7:0]                        bit_cycles,
    output logic                                   termination_on,
    output logic                                   cmd_seen,
    output logic      [7:0]                        cmd_byte
);
    import cnsc_pkg::*;

    // ==========================================================
    // Timing after reset release
    // ==========================================================
    // Edge 1: first synchroniser stage takes the selector pins
    // Edge 2: second stage holds them, sequence reaches the take state
    // Edge 3: held registers load; config_valid stands from then on
    // Selectors must stay put from release through edge 1,
    // or a dial caught mid-turn may give a mixed position
    // Later switch moves never reach the held values before reset
    // Requests before config_valid are dropped, not queued

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    localparam int PIN_W = DIAL_WIDTH + 1 + SEL_WIDTH + 1;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;

    // First stage is read only by the second
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {line_termination_select, mode_switch, address_high, address_dial};
            pin_sync <= pin_meta;
        end
    end

    // ==========================================================
    // Capture sequence after reset release
    // ==========================================================
    // Wait states let the two synchroniser stages fill with real pin values
    typedef enum logic [3:0]
    {
        CNSC_ST_WAIT1 = 4'b0001,
        CNSC_ST_WAIT2 = 4'b0010,
        CNSC_ST_TAKE  = 4'b0100,
        CNSC_ST_HOLD  = 4'b1000
    } cnsc_state_t;

    cnsc_state_t state;
    cnsc_state_t next_state;

    always_comb
    begin
        case (state)
            CNSC_ST_WAIT1: next_state = CNSC_ST_WAIT2;
            CNSC_ST_WAIT2: next_state = CNSC_ST_TAKE;
            CNSC_ST_TAKE:  next_state = CNSC_ST_HOLD;
            CNSC_ST_HOLD:  next_state = CNSC_ST_HOLD;
            default:       next_state = CNSC_ST_WAIT1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state <= CNSC_ST_WAIT1;
        else
            state <= next_state;
    end

    // Rate decode, used for the held rate and the bit time
    function automatic cnsc_rate_t decode_rate(input logic rate_lo, input logic rate_hi);
        // on/on 1000, off/on 800, on/off 500, off/off 250
        decode_rate = cnsc_rate_t'({~rate_hi, ~rate_lo});
    endfunction

    function automatic logic [7:0] rate_cycles(input cnsc_rate_t r);
        case (r)
            CNSC_RATE_1000: rate_cycles = BIT_CYC_1000;
            CNSC_RATE_800:  rate_cycles = BIT_CYC_800;
            CNSC_RATE_500:  rate_cycles = BIT_CYC_500;
            default:        rate_cycles = BIT_CYC_250;
        endcase
    endfunction

    // ==========================================================
    // Held configuration
    // ==========================================================
    logic [NODE_WIDTH-1:0] node_q;
    cnsc_proto_t           proto_q;
    cnsc_rate_t            rate_q;
    logic                  term_q;
    logic                  held;

    // Taken once; later switch moves are ignored until the next reset
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            node_q  <= NODE_RESET;
            proto_q <= cnsc_proto_t'(PROTOCOL_RESET);
            rate_q  <= cnsc_rate_t'(RATE_RESET);
            term_q  <= 1'b0;
            held    <= 1'b0;
        end
        else if (state == CNSC_ST_TAKE)
        begin
            node_q  <= {pin_sync[DIAL_WIDTH],
                        pin_sync[DIAL_WIDTH-1:0]};
            proto_q <= cnsc_proto_t'(pin_sync[DIAL_WIDTH+1+SEL_PROTOCOL_BIT]);
            rate_q  <= decode_rate(pin_sync[DIAL_WIDTH+1+SEL_RATE_LO_BIT],
                                   pin_sync[DIAL_WIDTH+1+SEL_RATE_HI_BIT]);
            term_q  <= pin_sync[PIN_W-1];
            held    <= 1'b1;
        end
    end

    // Lower position wins arbitration, so priority equals the position
    assign node_priority  = node_q;
    // Bit time matters only in open mode; proprietary runs its own default rate
    assign bit_cycles     = rate_cycles(rate_q);
    assign termination_on = term_q;

    assign link.node_id      = node_q;
    assign link.protocol     = proto_q;
    assign link.rate         = rate_q;
    assign link.config_valid = held;

    // ==========================================================
    // Traffic routing
    // ==========================================================
    // Keys leave on the bus path, never before the configuration is held
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link.key_valid <= 1'b0;
            link.key_data  <= 8'h00;
        end
        else
        begin
            link.key_valid <= key_req & held;
            if (key_req)
                link.key_data <= key_byte;
        end
    end

    // Pointer bytes use their own port, so they never load the bus
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link.ptr_valid <= 1'b0;
            link.ptr_data  <= 8'h00;
        end
        else
        begin
            link.ptr_valid <= ptr_req & held;
            if (ptr_req)
                link.ptr_data <= ptr_byte;
        end
    end

    // Commands count only once both ends hold their settings
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_seen <= 1'b0;
            cmd_byte <= 8'h00;
        end
        else
        begin
            cmd_seen <= link.cmd_valid & held & link.ctrl_ready;
            if (link.cmd_valid)
                cmd_byte <= link.cmd_data;
        end
    end

endmodule

/* cnsc_assertions.sv */
// Checker of held configuration and traffic gating on the node link
`timescale 1ns/1ps
module cnsc_assertions
(
    // Clock and reset
    input wire logic                           clk_sys,
    input wire logic                           reset_n,
    // Link signals
    input wire logic [cnsc_pkg::NODE_WIDTH-1:0] node_id,
    input wire cnsc_pkg::cnsc_rate_t           rate,
    input wire cnsc_pkg::cnsc_proto_t          protocol,
    input wire logic                           config_valid,
    input wire logic                           ctrl_ready,
    input wire logic                           key_valid,
    input wire logic                           ptr_valid
);
    import cnsc_pkg::*;

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Held values must not follow the pins after capture
    property p_node_hold; config_valid |=> $stable(node_id); endproperty
    property p_rate_hold; config_valid |=> $stable(rate); endproperty
    property p_proto_hold; config_valid |=> $stable(protocol); endproperty
    property p_cfg_stays; config_valid |=> config_valid; endproperty
    // Held values load at the third edge after release, so config_valid samples low for three edges
    property p_cfg_latency; $rose(reset_n) |-> !config_valid [*3] ##1 config_valid; endproperty
    property p_reset_vals; $rose(reset_n) |-> rate == CNSC_RATE_250 && node_id == NODE_RESET;
    endproperty
    property p_ready_latency; $rose(reset_n) |-> !ctrl_ready ##1 ctrl_ready; endproperty
    // No traffic may leave before the position is known
    property p_key_gate; key_valid |-> config_valid; endproperty
    property p_ptr_gate; ptr_valid |-> config_valid; endproperty

    a_node_hold: assert property (p_node_hold) else $error("node id moved");
    a_rate_hold: assert property (p_rate_hold) else $error("rate moved");
    a_proto_hold: assert property (p_proto_hold) else $error("protocol moved");
    a_cfg_stays: assert property (p_cfg_stays) else $error("config dropped");
    a_cfg_latency: assert property (p_cfg_latency) else $error("capture late");
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
    a_ready_latency: assert property (p_ready_latency) else $error("ready late");
    a_key_gate: assert property (p_key_gate) else $error("key before config");
    a_ptr_gate: assert property (p_ptr_gate) else $error("ptr before config");

    c_open: cover property (config_valid && protocol == CNSC_PROTO_OPEN);
    c_high: cover property (config_valid && node_id[4]);
    c_keys: cover property (key_valid ##1 key_valid);
endmodule

/* can_node_switch_config_tb.sv */
// Bench joining node and controller ends over the link
`timescale 1ns/1ps
module can_node_switch_config_tb;
    import cnsc_pkg::*;

    // ==========================================================
    // Signals
    // ==========================================================
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  dial;
    logic [2:0]  mode_sw;
    logic [1:0]  rate_cfg;
    logic        adr_hi, lt_sel, key_req, ptr_req, cmd_req;
    logic [7:0]  key_in, ptr_in, cmd_in, key_out, ptr_out, cmd_out, bit_cycles;
    logic [4:0]  node_priority, seen_node;
    logic        termination_on, cmd_seen, node_bad, rate_mismatch, key_seen, ptr_seen;
    logic [31:0] seed = 32'h8DAD;
    logic [7:0]  kq[$], pq[$], cq[$];
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    cnsc_if u_cnsc_if ();
    cnsc_node u_cnsc_node
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .address_dial(dial), .address_high(adr_hi),
        .mode_switch(mode_sw), .line_termination_select(lt_sel), .link(u_cnsc_if.node),
        .key_req(key_req), .key_byte(key_in), .ptr_req(ptr_req), .ptr_byte(ptr_in),
        .node_priority(node_priority), .bit_cycles(bit_cycles),
        .termination_on(termination_on), .cmd_seen(cmd_seen), .cmd_byte(cmd_out)
    );
    cnsc_ctrl u_cnsc_ctrl
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .link(u_cnsc_if.ctrl), .rate_cfg(rate_cfg),
        .cmd_req(cmd_req), .cmd_byte(cmd_in), .seen_node(seen_node), .node_bad(node_bad),
        .rate_mismatch(rate_mismatch), .key_seen(key_seen), .key_byte(key_out),
        .ptr_seen(ptr_seen), .ptr_byte(ptr_out)
    );
    cnsc_assertions u_cnsc_assertions
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .node_id(u_cnsc_if.node_id),
        .rate(u_cnsc_if.rate), .protocol(u_cnsc_if.protocol),
        .config_valid(u_cnsc_if.config_valid), .ctrl_ready(u_cnsc_if.ctrl_ready),
        .key_valid(u_cnsc_if.key_valid), .ptr_valid(u_cnsc_if.ptr_valid)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    always #50 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reset with new pins, then disturb them; held values must not move
    task automatic run_case(input int i);
        logic [4:0] exp_node;
        logic [7:0] exp_cyc;
        @(posedge clk_sys);
        seed = lfsr(seed);
        reset_n  <= 1'b0;
        dial     <= (i == 0) ? 4'h0 : seed[3:0];
        adr_hi   <= i[0] ^ i[2];
        mode_sw  <= {i[1], i[0], i[2]}; // Each rate a bus length may need
        lt_sel   <= seed[4];
        rate_cfg <= (i == 5) ? 2'h0 : {~i[1], ~i[0]};
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        // Too early on every path, must vanish
        key_req <= 1'b1;
        ptr_req <= 1'b1;
        cmd_req <= 1'b1;
        @(posedge clk_sys);
        key_req <= 1'b0;
        ptr_req <= 1'b0;
        cmd_req <= 1'b0;
        repeat (6) @(posedge clk_sys);
        exp_node = {adr_hi, dial};
        exp_cyc  = 8'(CLK_KHZ / (mode_sw[1] ? (mode_sw[2] ? RATE_1000_KHZ : RATE_500_KHZ)
                                            : (mode_sw[2] ? RATE_800_KHZ : RATE_250_KHZ)));
        seed = lfsr(seed);
        dial    <= seed[3:0];
        adr_hi  <= ~adr_hi;
        mode_sw <= ~mode_sw;
        lt_sel  <= ~lt_sel;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check(8'(node_priority), 8'(exp_node));
        check(8'(seen_node), 8'(exp_node));
        check(8'(node_bad), 8'(exp_node == 5'h00));
        check(8'(termination_on), {7'h00, ~lt_sel});
        check(8'(u_cnsc_if.protocol), {7'h00, ~mode_sw[0]});
        check(8'(rate_mismatch), 8'(i == 5));
        check(8'(u_cnsc_if.ctrl_rate), {6'h00, rate_cfg});
        if (mode_sw[0] == 1'b0)
            check(bit_cycles, exp_cyc);
    endtask

    // Back-to-back bytes each way, noted as they are sent
    task automatic traffic();
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk_sys);
            seed = lfsr(seed);
            key_req <= 1'b1;
            key_in  <= seed[7:0];
            ptr_req <= (k < 2);
            ptr_in  <= seed[15:8];
            cmd_req <= 1'b1;
            cmd_in  <= seed[23:16];
            kq.push_back(seed[7:0]);
            if (k < 2)
                pq.push_back(seed[15:8]);
            cq.push_back(seed[23:16]);
        end
        @(posedge clk_sys);
        key_req <= 1'b0;
        ptr_req <= 1'b0;
        cmd_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    // Watcher: an empty queue yields an unknown note, so a stray strobe fails
    always @(negedge clk_sys)
    begin
        if (key_seen === 1'b1)
            check(key_out, (kq.size() > 0) ? kq.pop_front() : 8'hXX);
        if (ptr_seen === 1'b1)
            check(ptr_out, (pq.size() > 0) ? pq.pop_front() : 8'hXX);
        if (cmd_seen === 1'b1)
            check(cmd_out, (cq.size() > 0) ? cq.pop_front() : 8'hXX);
    end

    // Ceiling far above eight cases of some twenty cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fail_count++;
            results();
        end
    end

    // Main sequence
    initial
    begin
        {dial, adr_hi, mode_sw, lt_sel, rate_cfg} = '0;
        {key_req, key_in, ptr_req, ptr_in, cmd_req, cmd_in} = '0;
        repeat (12) @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            run_case(i);
            traffic();
        end
        check(8'(kq.size() + pq.size() + cq.size()), 8'h00);
        results();
    end
endmodule
